// file: pkg/eivc_pkg.sv
// Purpose: Shared constants and types for the external interrupt and vector block
// Assumes: AXI4-Lite register access, 32-bit data, one aligned word per register
// Notes:   Register offsets are chosen locally since none are printed
package eivc_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [3:0] ADDR_SENSE    = 4'h0;
    localparam logic [3:0] ADDR_PIN_SEL  = 4'h4;
    localparam logic [3:0] ADDR_CPU_CTRL = 4'h8;
    localparam logic [3:0] ADDR_STATUS   = 4'hc;
    localparam logic [7:0] SENSE_RESET   = 8'h00;
    localparam logic [7:0] PIN_SEL_RESET = 8'h0c;

    // CPU control register bits
    localparam int CTRL_IMASK_BIT = 0;
    localparam int CTRL_ACK_BIT   = 1;
    localparam int CTRL_HALT_BIT  = 2;
    localparam int CTRL_AHALT_BIT = 3;
    localparam int CTRL_AUTO_WAKE_BIT = 4;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ************************************************************
    // Sensitivity codes
    // ************************************************************
    typedef enum logic [1:0]
    {
        SENSE_FALL_LOW = 2'h0,
        SENSE_RISE     = 2'h1,
        SENSE_FALL     = 2'h2,
        SENSE_BOTH     = 2'h3
    } eivc_sense_type;

    // ************************************************************
    // Source numbering, lowest number is highest priority
    // ************************************************************
    localparam int NUM_SRC       = 14;
    localparam int SRC_AUTO_WAKE = 0;
    localparam int SRC_EXT0      = 1;
    localparam int SRC_EXT3      = 4;
    localparam int SRC_TB2       = 5;
    localparam int SRC_UNUSED_A  = 6;
    localparam int SRC_AVD       = 7;
    localparam int SRC_AT_CMP    = 8;
    localparam int SRC_AT_OVF    = 9;
    localparam int SRC_LT_CAP    = 10;
    localparam int SRC_TB1       = 11;
    localparam int SRC_SPI       = 12;
    localparam int SRC_UNUSED_B  = 13;
    localparam logic [15:0] VECTOR_TOP = 16'hfffa;
    localparam logic [15:0] VECTOR_STEP = 16'h0002;

    // Wake masks per source, bit n = source n
    localparam logic [13:0] WAKE_HALT  = 14'h101e;
    localparam logic [13:0] WAKE_AUTO_WAKE_HALT_MODE = 14'h101f;
    localparam logic [13:0] WAKE_AHALT = 14'h0a00;
    localparam logic [13:0] SRC_USED   = 14'h1fbf;

    typedef struct packed
    {
        logic        valid;
        logic [3:0]  number;
        logic [15:0] vector;
    } eivc_request_type;

endpackage : eivc_pkg

// file: hw/eivc_edge_detect.sv
// Purpose: Synchronise one selected pin and flag its sensitivity events
// Assumes: Pin is asynchronous to aclk
// Notes:   First flop feeds only the second flop
module eivc_edge_detect
(
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    input  wire logic                    pin,
    input  wire eivc_pkg::eivc_sense_type sense,
    output logic                         edge_event,
    output logic                         low_level
);
    logic meta;
    logic sync;
    logic prev;
    wire  rise = sync & ~prev;
    wire  fall = ~sync & prev;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            meta <= 1'b1;
            sync <= 1'b1;
            prev <= 1'b1;
        end
        else
        begin
            meta <= pin;   // R19
            sync <= meta;  // R19
            prev <= sync;
        end
    end

    always_comb
    begin
        unique case (sense)  // R08
            eivc_pkg::SENSE_FALL_LOW: edge_event = fall;
            eivc_pkg::SENSE_RISE:     edge_event = rise;
            eivc_pkg::SENSE_FALL:     edge_event = fall;
            eivc_pkg::SENSE_BOTH:     edge_event = rise | fall;
        endcase
    end

    assign low_level = (sense == eivc_pkg::SENSE_FALL_LOW) & ~sync;  // R08

    chk_rise_only: assert property (@(posedge aclk) disable iff (!aresetn)  // R08
        (sense == eivc_pkg::SENSE_RISE && edge_event) |-> (sync && !prev))
        else $error("rise sense fired without rising edge");

endmodule : eivc_edge_detect

// file: hw/eivc_prio_encode.sv
// Purpose: Fixed priority selection of the pending interrupt and its vector
// Assumes: Bit 0 is the highest priority source
// Notes:   Purely combinational
module eivc_prio_encode
(
    input  wire logic [13:0]               active,
    output eivc_pkg::eivc_request_type     request
);
    always_comb
    begin
        request = '0;
        for (int i = eivc_pkg::NUM_SRC - 1; i >= 0; i--)
        begin
            if (active[i])  // R16
            begin
                request.valid  = 1'b1;
                request.number = 4'(i);
                request.vector = eivc_pkg::VECTOR_TOP - 16'(i) * eivc_pkg::VECTOR_STEP;
            end
        end
    end
endmodule : eivc_prio_encode

// file: hw/eivc_top.sv
// Purpose: External interrupt configuration, latching, priority and vector mapping
// Assumes: AXI4-Lite slave on aclk; pins asynchronous; CPU state given by software
// Notes:   Outputs are registered
//
// Functional notes
// R01: Auto wake-up vector FFFA, wakes auto-wake halt only
// R02: Second time base vector FFF0, no halt wake
// R03: Timer compare/capture share FFEA, no active-halt
// R04: Timer overflow FFE8, wakes active-halt, not halt
// R05: Light timer capture FFE6, no active-halt wake
// R06: First time base FFE4, wakes active-halt
// R07: Sensitivity register holds four two-bit fields
// R08: Sense codes: fall+low, rise, fall, both
// R09: Sensitivity writes only while CPU mask set
// R10: Input 3 selects port B bits 0..2
// R11: Input 2 selects port B bits 3..6
// R12: Input 1 selects port A bits 4..7
// R13: Input 0 pin field bits 1:0, writable
// R14: Port B bit four ignored while halted
// R15: Input 0 selects port A bits 0..3
// R16: Highest fixed priority pending serviced first
// R17: Edge requests latch, cleared at service entry
// R18: Unused codes connect nothing; unused vectors silent
// R19: Pins synchronised before edge or level detect
//
// The address map and the AXI4-Lite register port were decided locally.
module eivc_top
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [7:0]  port_a,
    input  wire logic [6:0]  port_b,
    input  wire logic [13:0] periph_req,
    output logic             irq_valid,
    output logic [3:0]       irq_number,
    output logic [15:0]      irq_vector,
    output logic             wake
);

    // ************************************************************
    // Register state
    // ************************************************************
    logic [7:0]  ext_int_sensitivity;
    logic [7:0]  ext_int_pin_select;
    logic        cpu_imask;
    logic        halt_mode;
    logic        ahalt_mode;
    logic        auto_wake_halt_mode;
    logic [3:0]  ext_pending;
    logic        aw_held;
    logic        w_held;
    logic [3:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        aw_hi_ok;

    // ************************************************************
    // Bus decode
    // ************************************************************
    wire       wr_fire    = aw_held & w_held & ~s_axi_bvalid;
    // Refused addresses answer an error and must not touch any register
    wire       wr_ok      = wr_fire & aw_hi_ok;
    wire       wr_sense   = wr_ok & (aw_addr == eivc_pkg::ADDR_SENSE) & w_strb[0];
    wire       wr_pin     = wr_ok & (aw_addr == eivc_pkg::ADDR_PIN_SEL) & w_strb[0];
    wire       wr_ctrl    = wr_ok & (aw_addr == eivc_pkg::ADDR_CPU_CTRL) & w_strb[0];
    wire       wr_mapped  = (aw_addr == eivc_pkg::ADDR_SENSE) |
                            (aw_addr == eivc_pkg::ADDR_PIN_SEL) |
                            (aw_addr == eivc_pkg::ADDR_CPU_CTRL) |
                            (aw_addr == eivc_pkg::ADDR_STATUS);
    wire       sense_ok   = wr_sense & cpu_imask;  // R09
    wire       ack_pulse  = wr_ctrl & w_data[eivc_pkg::CTRL_ACK_BIT];
    wire       rd_fire    = s_axi_arvalid & s_axi_arready;
    wire [3:0] rd_addr    = s_axi_araddr[3:0];
    wire       rd_mapped  = (rd_addr == eivc_pkg::ADDR_SENSE) |
                            (rd_addr == eivc_pkg::ADDR_PIN_SEL) |
                            (rd_addr == eivc_pkg::ADDR_CPU_CTRL) |
                            (rd_addr == eivc_pkg::ADDR_STATUS);
    wire       word_ok_rd = (s_axi_araddr[31:4] == 28'h0000000) & rd_mapped;

    // ************************************************************
    // Pin selection
    // ************************************************************
    wire [1:0] sel3 = ext_int_pin_select[7:6];  // R10
    wire [1:0] sel2 = ext_int_pin_select[5:4];  // R11
    wire [1:0] sel1 = ext_int_pin_select[3:2];  // R12
    wire [1:0] sel0 = ext_int_pin_select[1:0];  // R13
    wire [3:0] pin_sel;
    wire       port_b_bit_four_sel = (sel2 == 2'h1);

    // Code 11 on input 3 reads as an idle high pin
    assign pin_sel[3] = (sel3 == 2'h3) ? 1'b1 : port_b[sel3];  // R10 R18
    assign pin_sel[2] = port_b[3'(sel2) + 3'h3];               // R11
    assign pin_sel[1] = port_a[3'(sel1) + 3'h4];               // R12
    assign pin_sel[0] = port_a[3'(sel0)];                      // R15

    logic [3:0] edge_ev;
    logic [3:0] low_lvl;

    for (genvar g = 0; g < 4; g++)
    begin : g_ext
        eivc_edge_detect u_det
        (
            .aclk       (aclk),
            .aresetn    (aresetn),
            .pin        (pin_sel[g]),
            .sense      (eivc_pkg::eivc_sense_type'(ext_int_sensitivity[2*g +: 2])),  // R07
            .edge_event (edge_ev[g]),
            .low_level  (low_lvl[g])
        );
    end

    // Port B bit four gives no interrupt while halted
    wire       port_b_bit_four_block = port_b_bit_four_sel & halt_mode;  // R14
    wire [3:0] ext_mask  = {1'b1, ~port_b_bit_four_block, 2'b11};
    wire [3:0] ext_set   = edge_ev & ext_mask;
    wire [3:0] ext_level = low_lvl & ext_mask;

    // ************************************************************
    // Interrupt selection
    // ************************************************************
    wire [3:0] ext_active = ext_pending | ext_level;
    wire [13:0] active = ((periph_req & ~(14'h001e)) |
                          {9'h000, ext_active, 1'b0}) & eivc_pkg::SRC_USED;  // R18
    eivc_pkg::eivc_request_type req;

    eivc_prio_encode u_prio
    (
        .active  (active),
        .request (req)
    );

    wire wake_now = (halt_mode & |(active & eivc_pkg::WAKE_HALT)) |             // R02 R04
                    (auto_wake_halt_mode & |(active & eivc_pkg::WAKE_AUTO_WAKE_HALT_MODE)) |  // R01
                    (ahalt_mode & |(active & eivc_pkg::WAKE_AHALT));            // R03 R05 R06

    // Ack clears the latch of the source being serviced; a new edge still wins
    wire [3:0] ack_ext = (ack_pulse && irq_valid && irq_number >= 4'(eivc_pkg::SRC_EXT0) &&
                          irq_number <= 4'(eivc_pkg::SRC_EXT3)) ?
                         4'(4'h1 << (irq_number - 4'(eivc_pkg::SRC_EXT0))) : 4'h0;
    wire [3:0] next_ext_pending = (ext_pending & ~ack_ext) | ext_set;  // R17

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ext_int_sensitivity <= eivc_pkg::SENSE_RESET;
            ext_int_pin_select  <= eivc_pkg::PIN_SEL_RESET;
            cpu_imask           <= 1'b1;
            halt_mode           <= 1'b0;
            ahalt_mode          <= 1'b0;
            auto_wake_halt_mode <= 1'b0;
            ext_pending         <= 4'h0;
        end
        else
        begin
            if (sense_ok)
                ext_int_sensitivity <= w_data[7:0];  // R07 R09
            if (wr_pin)
                ext_int_pin_select <= w_data[7:0];   // R13
            if (wr_ctrl)
            begin
                cpu_imask           <= w_data[eivc_pkg::CTRL_IMASK_BIT];
                halt_mode           <= w_data[eivc_pkg::CTRL_HALT_BIT];
                ahalt_mode          <= w_data[eivc_pkg::CTRL_AHALT_BIT];
                auto_wake_halt_mode <= w_data[eivc_pkg::CTRL_AUTO_WAKE_BIT];
            end
            ext_pending <= next_ext_pending;  // R17
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            irq_valid  <= 1'b0;
            irq_number <= 4'h0;
            irq_vector <= 16'h0000;
            wake       <= 1'b0;
        end
        else
        begin
            irq_valid  <= req.valid & ~cpu_imask;  // R16
            irq_number <= req.number;
            irq_vector <= req.vector;              // R01 R02 R03 R04 R05 R06
            wake       <= wake_now;
        end
    end

    // ************************************************************
    // AXI4-Lite slave
    // ************************************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= 4'h0;
            aw_hi_ok      <= 1'b0;
            w_data        <= 32'h00000000;
            w_strb        <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= eivc_pkg::RESP_OKAY;
        end
        else
        begin
            s_axi_awready <= ~aw_held & ~s_axi_awready & s_axi_awvalid;
            s_axi_wready  <= ~w_held & ~s_axi_wready & s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held  <= 1'b1;
                aw_addr  <= s_axi_awaddr[3:0];
                aw_hi_ok <= (s_axi_awaddr[31:4] == 28'h0000000);
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_fire)
            begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (wr_mapped & aw_hi_ok) ? eivc_pkg::RESP_OKAY
                                                       : eivc_pkg::RESP_SLVERR;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    logic [31:0] rd_word;
    always_comb
    begin
        rd_word = 32'h00000000;
        unique case (rd_addr)
            eivc_pkg::ADDR_SENSE:    rd_word = {24'h000000, ext_int_sensitivity};
            eivc_pkg::ADDR_PIN_SEL:  rd_word = {24'h000000, ext_int_pin_select};
            eivc_pkg::ADDR_CPU_CTRL: rd_word = {27'h0000000, auto_wake_halt_mode, ahalt_mode,
                                                halt_mode, 1'b0, cpu_imask};
            eivc_pkg::ADDR_STATUS:   rd_word = {8'h00, irq_vector, irq_number, ext_pending};
            default:                 rd_word = 32'h00000000;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= eivc_pkg::RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
            if (rd_fire)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= word_ok_rd ? rd_word : 32'h00000000;
                s_axi_rresp  <= word_ok_rd ? eivc_pkg::RESP_OKAY : eivc_pkg::RESP_SLVERR;
            end
            else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    chk_sense_locked: assert property (@(posedge aclk) disable iff (!aresetn)  // R09
        (wr_sense && !cpu_imask) |=> $stable(ext_int_sensitivity))
        else $error("sensitivity changed while mask clear");

    chk_pending_kept: assert property (@(posedge aclk) disable iff (!aresetn)  // R17
        (ext_pending[0] && !ack_ext[0]) |=> ext_pending[0])
        else $error("pending edge lost without service");

    chk_pending_cleared: assert property (@(posedge aclk) disable iff (!aresetn)  // R17
        (ack_ext[1] && !ext_set[1]) |=> !ext_pending[1])
        else $error("serviced edge not cleared");

    chk_auto_wake_vector: assert property (@(posedge aclk) disable iff (!aresetn)  // R01
        (active[eivc_pkg::SRC_AUTO_WAKE] && !cpu_imask) |=>
        (irq_valid && irq_vector == 16'hfffa))
        else $error("auto wake-up vector wrong");

    chk_auto_wake_only: assert property (@(posedge aclk) disable iff (!aresetn)  // R01
        (active == 14'h0001 && !auto_wake_halt_mode) |=> !wake)
        else $error("auto wake-up woke outside its mode");

    chk_cmp_no_ahalt: assert property (@(posedge aclk) disable iff (!aresetn)  // R03
        (active == 14'h0100 && !halt_mode && !auto_wake_halt_mode) |=> !wake)
        else $error("compare event woke from active-halt");

    chk_cap_no_ahalt: assert property (@(posedge aclk) disable iff (!aresetn)  // R05
        (active == 14'h0400 && !halt_mode && !auto_wake_halt_mode) |=> !wake)
        else $error("capture event woke from active-halt");

    chk_ovf_vector: assert property (@(posedge aclk) disable iff (!aresetn)  // R04
        (active == 14'h0200 && !cpu_imask) |=> (irq_vector == 16'hffe8))
        else $error("overflow vector wrong");

    chk_tb2_nohalt: assert property (@(posedge aclk) disable iff (!aresetn)  // R02
        (active == 14'h0020 && !ahalt_mode && !auto_wake_halt_mode) |=> !wake)
        else $error("second time base woke from halt");

    chk_tb1_ahalt: assert property (@(posedge aclk) disable iff (!aresetn)  // R06
        (active[eivc_pkg::SRC_TB1] && ahalt_mode) |=> wake)
        else $error("first time base failed to wake");

    chk_unused_silent: assert property (@(posedge aclk) disable iff (!aresetn)  // R18
        irq_valid |-> (irq_number != 4'(eivc_pkg::SRC_UNUSED_A) &&
                       irq_number != 4'(eivc_pkg::SRC_UNUSED_B)))
        else $error("unused vector raised");

    chk_bit_four_halt: assert property (@(posedge aclk) disable iff (!aresetn)  // R14
        (port_b_bit_four_block && !ext_pending[2]) |=> !ext_pending[2])
        else $error("port b bit four fired in halt");

    cov_ext_edge: cover property (@(posedge aclk) disable iff (!aresetn) ext_set[0]);
    cov_ack: cover property (@(posedge aclk) disable iff (!aresetn) |ack_ext);
    cov_wake: cover property (@(posedge aclk) disable iff (!aresetn) wake_now);

endmodule : eivc_top

// file: verification/eivc_pin_model.sv
// Purpose: Port pin and peripheral request model facing the block
// Assumes: Pins idle high through pull-ups
// Notes:   Changes land by non-blocking assignment after a rising edge
module eivc_pin_model
(
    input  wire logic        aclk,
    output logic [7:0]       port_a,
    output logic [6:0]       port_b,
    output logic [13:0]      periph_req
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        port_a     = 8'hff;
        port_b     = 7'h7f;
        periph_req = 14'h0000;
    end

    // Index 0..7 is port A, 8..14 is port B
    task set_pin(input int idx, input logic val);
        @(posedge aclk);
        if (idx < 8)
            port_a[idx] <= val;
        else
            port_b[idx - 8] <= val;
    endtask : set_pin

    task set_req(input logic [13:0] req);
        @(posedge aclk);
        periph_req <= req;
    endtask : set_req
endmodule : eivc_pin_model

// file: verification/eivc_tb.sv
// Purpose: Self-checking bench for the external interrupt and vector block
// Assumes: Offsets and control bits from the shared package
// Notes:   Pins and peripheral requests come from the pin model
module eivc_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] A_SEN = {28'h0, eivc_pkg::ADDR_SENSE};
    localparam logic [31:0] A_SEL = {28'h0, eivc_pkg::ADDR_PIN_SEL};
    localparam logic [31:0] A_CTL = {28'h0, eivc_pkg::ADDR_CPU_CTRL};
    logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_rready;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, rd_val;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  rsp;
    logic        wx;
    wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire logic [1:0]  s_axi_bresp, s_axi_rresp;
    wire logic [31:0] s_axi_rdata;
    wire logic [7:0]  port_a;
    wire logic [6:0]  port_b;
    wire logic [13:0] periph_req;
    wire logic        irq_valid, wake;
    wire logic [3:0]  irq_number;
    wire logic [15:0] irq_vector;
    int err_count, n_compared, k, c, p, s;
    int srcs [8] = '{0, 5, 7, 8, 9, 10, 11, 12};

    eivc_top dut
    (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .port_a, .port_b, .periph_req,
        .irq_valid, .irq_number, .irq_vector, .wake
    );
    eivc_pin_model pins (.aclk, .port_a, .port_b, .periph_req);

    initial
    begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    // ****
    // Bus tasks and compares
    // ****
    task print_verdict;
        $display("errors %0d compared %0d", err_count, n_compared);
        if (err_count == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict

    task cmp_val(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask : cmp_val

    // Vector is the top slot minus two per source number
    task cmp_irq(input logic v, input logic [3:0] num);
        logic [15:0] vec;
        vec = 16'hfffa - {11'h0, num, 1'b0};
        if (v)
            cmp_val({11'h0, irq_valid, irq_number, irq_vector}, {11'h0, 1'b1, num, vec});
        else
            cmp_val({31'h0, irq_valid}, 32'h0);
    endtask : cmp_irq

    task guard(inout int n);
        n++;
        if (n > 100)
        begin
            err_count++;
            $display("timeout at %0t", $time);
            print_verdict();
        end
    endtask : guard

    task wr(input logic [31:0] a, input logic [31:0] d);
        int   n;
        logic aw_ok, w_ok;
        n = 0;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_ok && w_ok))
        begin
            @(posedge aclk);
            aw_ok = aw_ok || s_axi_awready === 1'b1;
            w_ok = w_ok || s_axi_wready === 1'b1;
            s_axi_awvalid <= !aw_ok;
            s_axi_wvalid <= !w_ok;
            guard(n);
        end
        while (s_axi_bvalid !== 1'b1)
        begin
            @(posedge aclk);
            guard(n);
        end
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr

    task rd(input logic [31:0] a);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (s_axi_arready !== 1'b1)
        begin
            @(posedge aclk);
            guard(n);
        end
        s_axi_arvalid <= 1'b0;
        while (s_axi_rvalid !== 1'b1)
        begin
            @(posedge aclk);
            guard(n);
        end
        rd_val = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd

    task chk(input logic [31:0] a, input logic [31:0] exp);
        rd(a);
        cmp_val(rd_val, exp);
    endtask : chk

    task ctl(input logic [31:0] d);
        wr(A_CTL, d);
        repeat (2) @(posedge aclk);
    endtask : ctl

    task sense(input logic [31:0] code);
        ctl(32'h1);
        wr(A_SEN, code);
        ctl(32'h0);
    endtask : sense

    // Move one pin, check the request, acknowledge, check again
    task edge_chk(input int pin, input logic lvl, input logic v1, input logic v2,
                  input logic [3:0] num);
        pins.set_pin(pin, lvl);
        repeat (8) @(posedge aclk);
        cmp_irq(v1, num);
        ctl(32'h2);
        cmp_irq(v2, num);
    endtask : edge_chk

    // ****
    // Test sequence
    // ****
    initial
    begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
        {s_axi_rready, s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
        s_axi_wstrb = 4'hf;
        err_count = 0;
        n_compared = 0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        cmp_irq(1'b0, 4'h0);
        chk(A_SEN, 32'h00);
        chk(A_SEL, 32'h0c);
        rd(32'h0000_0010);
        cmp_val({30'h0, rsp}, {30'h0, eivc_pkg::RESP_SLVERR});
        wr(32'h0000_0014, 32'h00);
        cmp_val({30'h0, rsp}, {30'h0, eivc_pkg::RESP_SLVERR});
        chk(A_SEL, 32'h0c);
        wr(A_SEN, 32'h1b);
        chk(A_SEN, 32'h1b);
        wr(A_SEL, 32'h1b);
        chk(A_SEL, 32'h1b);
        ctl(32'h0);
        wr(A_SEN, 32'he4);
        chk(A_SEN, 32'h1b);
        sense(32'hff);
        for (k = 0; k < 4; k++)
            for (c = 0; c < 4; c++)
            begin
                p = (k == 0) ? c : (k == 1) ? 4 + c : (k == 2) ? 11 + c : 8 + c % 3;
                wr(A_SEL, 32'(c) << (2 * k));
                edge_chk(p, 1'b0, k < 3 || c < 3, 1'b0, 4'(k + 1));
                edge_chk(p, 1'b1, k < 3 || c < 3, 1'b0, 4'(k + 1));
            end
        wr(A_SEL, 32'h0);
        for (c = 0; c < 4; c++)
        begin
            sense(32'(c));
            edge_chk(0, 1'b0, c != 1, c == 0, 4'h1);
            edge_chk(0, 1'b1, c[0], 1'b0, 4'h1);
        end
        sense(32'hff);
        wr(A_SEL, 32'h10);
        ctl(32'h4);
        pins.set_pin(12, 1'b0);
        repeat (8) @(posedge aclk);
        cmp_irq(1'b0, 4'h3);
        cmp_val({31'h0, wake}, 32'h0);
        pins.set_pin(12, 1'b1);
        repeat (8) @(posedge aclk);
        ctl(32'h0);
        edge_chk(12, 1'b0, 1'b1, 1'b0, 4'h3);
        for (s = 0; s < 8; s++)
        begin
            pins.set_req(14'h1 << srcs[s]);
            repeat (6) @(posedge aclk);
            cmp_irq(1'b1, 4'(srcs[s]));
            for (c = 0; c < 3; c++)
            begin
                ctl(32'h4 << c);
                wx = (c == 0) ? eivc_pkg::WAKE_HALT[srcs[s]] :
                     (c == 1) ? eivc_pkg::WAKE_AHALT[srcs[s]] : eivc_pkg::WAKE_AUTO_WAKE_HALT_MODE[srcs[s]];
                cmp_val({31'h0, wake}, {31'h0, wx});
            end
            ctl(32'h0);
        end
        pins.set_req(14'h1a00);
        repeat (6) @(posedge aclk);
        cmp_irq(1'b1, 4'h9);
        pins.set_req(14'h2040);
        repeat (6) @(posedge aclk);
        cmp_irq(1'b0, 4'h0);
        print_verdict();
    end
endmodule : eivc_tb
